// ---- rtl/ars_pkg.sv ----
`default_nettype none
package ars_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CFG         = 8'h00;
  localparam logic [7:0] OFS_MAIN_GAIN   = 8'h04;
  localparam logic [7:0] OFS_MAIN_BIAS   = 8'h08;
  localparam logic [7:0] OFS_SECOND_GAIN = 8'h0c;
  localparam logic [7:0] OFS_SECOND_BIAS = 8'h10;
  localparam logic [7:0] OFS_THIRD_GAIN  = 8'h14;
  localparam logic [7:0] OFS_THIRD_BIAS  = 8'h18;
  localparam logic [7:0] OFS_FILTER      = 8'h1c;
  localparam logic [7:0] OFS_STATUS      = 8'h20;
  localparam logic [7:0] OFS_MAIN_REF    = 8'h24;
  localparam logic [7:0] OFS_SECOND_OUT  = 8'h28;
  localparam logic [7:0] OFS_THIRD_OUT   = 8'h2c;
  // ---------------------------------------------------------------
  // field layouts and codes
  // ---------------------------------------------------------------
  localparam int CFG_W = 14;
  typedef struct packed {
    logic [4:0] third_input_function_select;
    logic [4:0] second_input_function_select;
    logic [1:0] second_input_level_select;
    logic       third_input_level_select;
    logic       main_input_level_select;
  } ars_cfg_t;
  typedef struct packed {
    logic signed [15:0] gain;
    logic signed [15:0] bias;
  } ars_chan_t;
  localparam logic [1:0] LVL_UNIPOLAR = 2'h0;
  localparam logic [1:0] LVL_BIPOLAR  = 2'h1;
  localparam logic [1:0] LVL_CURRENT  = 2'h2;
  localparam logic [4:0] FN_BIAS_ADD  = 5'h00;
  localparam logic [4:0] FN_GAIN_ADD  = 5'h01;
  localparam int STS_RUN_BIT    = 0;
  localparam int STS_REJECT_BIT = 1;
  localparam int STS_JUMPER_BIT = 2;
  // ---------------------------------------------------------------
  // reset values and ranges, gain and bias in 0.1 % units, filter in 0.01 s units
  // ---------------------------------------------------------------
  localparam ars_cfg_t CFG_RST = '{5'h02, 5'h00, 2'h2, 1'b0, 1'b0};
  localparam logic signed [15:0] GAIN_RST = 16'sh03e8;
  localparam logic signed [15:0] BIAS_RST = 16'sh0000;
  localparam logic signed [15:0] GAIN_MAX = 16'sh2710;
  localparam logic signed [15:0] BIAS_MAX = 16'sh03e8;
  localparam logic signed [15:0] BIAS_MIN = -16'sh03e8;
  localparam logic [7:0] FILTER_RST = 8'h03;
  localparam logic [7:0] FILTER_MAX = 8'hc8;
  // ---------------------------------------------------------------
  // sample scaling and timing
  // ---------------------------------------------------------------
  localparam int          FS_SHIFT   = 11;
  localparam logic [10:0] MAG_FULL   = 11'h7ff;
  localparam logic [10:0] MAG_4MA    = 11'h19a;
  localparam int          CLK_MHZ    = 250;
  localparam int          FILTER_STEP_MS = 10;
  localparam int TICK_CYCLES_DEF = FILTER_STEP_MS * 1000 * CLK_MHZ;
  localparam int OUT_W = 18;
endpackage
`default_nettype wire

// ---- rtl/ars_scaler.sv ----
// Function
// - main level select: 0 unipolar 0..10 V, 1 bipolar -10..+10 V, reset 0.
// - bipolar samples arrive as 11-bit magnitude plus a sign bit.
// - main gain is the 10 V output in 0.1 % of max, 0..10000, reset 1000.
// - main bias is the output at 0 V, -1000..1000, reset 0.
// - third level select: 0 unipolar, 1 bipolar, reset 0.
// - second level select: 0 unipolar, 1 bipolar, 2 current, reset 2.
// - aux function codes 0..1F, second resets to 0 and third to 2.
// - aux gain is the output at 10 V, 0..10000, reset 1000.
// - aux bias is the output at 0 V, -1000..1000, reset 0.
// - one filter constant 0.00..2.00 s for all channels, reset 0.03 s.
// - aux function 1 adds its output to the effective main gain.
// - aux function 0 adds its output to the main reference as a bias.
// - third function code 0 is refused.
`default_nettype none
module ars_scaler
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                    CLK_SYS,
  input  wire logic                    NRST,
  input  wire logic [7:0]              WB_ADR,
  input  wire logic [31:0]             WB_DAT_I,
  input  wire logic [3:0]              WB_SEL,
  input  wire logic                    WB_WE,
  input  wire logic                    WB_STB,
  input  wire logic                    WB_CYC,
  output logic      [31:0]             WB_DAT_O,
  output logic                         WB_ACK,
  input  wire logic                    DRIVE_RUN,
  input  wire logic                    CURRENT_VOLTAGE_JUMPER,
  input  wire logic [10:0]             MAIN_REFERENCE_INPUT_MAG,
  input  wire logic                    MAIN_REFERENCE_INPUT_NEG,
  input  wire logic [10:0]             SECOND_REFERENCE_INPUT_MAG,
  input  wire logic                    SECOND_REFERENCE_INPUT_NEG,
  input  wire logic [10:0]             THIRD_REFERENCE_INPUT_MAG,
  input  wire logic                    THIRD_REFERENCE_INPUT_NEG,
  output logic signed [OUT_W-1:0]      MAIN_REF,
  output logic signed [OUT_W-1:0]      SECOND_OUT,
  output logic signed [OUT_W-1:0]      THIRD_OUT,
  output logic                         REF_STROBE
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  // sample to signed full scale of 2048
  function automatic logic signed [11:0] norm(input logic [10:0] mag,
                                              input logic        neg,
                                              input logic [1:0]  lvl);
    logic [13:0] cur;
    cur = 14'h0000;
    if (lvl == LVL_BIPOLAR) begin
      return neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    end else if (lvl == LVL_CURRENT) begin
      if (mag <= MAG_4MA || neg) begin
        return 12'sh000;
      end
      cur = 14'((({3'b000, mag} - {3'b000, MAG_4MA}) * 14'h0005) >> 2);
      return (cur > {3'b000, MAG_FULL}) ? $signed({1'b0, MAG_FULL})
                                         : $signed(cur[11:0]);
    end
    return neg ? 12'sh000 : $signed({1'b0, mag});
  endfunction

  function automatic logic signed [31:0] scale(
      input logic signed [11:0] s,
      input logic signed [31:0] g,
      input logic signed [31:0] b);
    return b + (((g - b) * 32'(s)) >>> FS_SHIFT);
  endfunction

  function automatic logic [4:0] shift_of(input logic [7:0] tau);
    logic [8:0] n;
    logic [4:0] k;
    n = {1'b0, tau};
    k = 5'h00;
    for (int i = 0; i < 9; i++) begin
      if ((9'h001 << i) <= n) begin
        k = 5'(i + 1);
      end
    end
    return (tau == 8'h00) ? 5'h00 : k;
  endfunction

  function automatic logic gain_ok(input logic [31:0] d);
    return $signed(d[15:0]) >= 16'sh0000 && $signed(d[15:0]) <= GAIN_MAX;
  endfunction

  function automatic logic bias_ok(input logic [31:0] d);
    return $signed(d[15:0]) >= BIAS_MIN && $signed(d[15:0]) <= BIAS_MAX;
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  ars_cfg_t    cfg_reg;
  ars_chan_t   main_reg;
  ars_chan_t   second_reg;
  ars_chan_t   third_reg;
  logic [7:0]  filter_reg;
  logic        reject_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] wval;
  ars_cfg_t    cfg_new;
  logic        wr_fire;

  assign wr_fire = WB_CYC && WB_STB && WB_WE && ack_reg;
  assign WB_ACK  = ack_reg;
  assign WB_DAT_O = rdata_reg;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= WB_CYC && WB_STB && !ack_reg;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (WB_ADR)
      OFS_CFG:         rdata_next = {18'h0_0000, cfg_reg};
      OFS_MAIN_GAIN:   rdata_next = {{16{main_reg.gain[15]}}, main_reg.gain};
      OFS_MAIN_BIAS:   rdata_next = {{16{main_reg.bias[15]}}, main_reg.bias};
      OFS_SECOND_GAIN: rdata_next = 32'(second_reg.gain);
      OFS_SECOND_BIAS: rdata_next = 32'(second_reg.bias);
      OFS_THIRD_GAIN:  rdata_next = 32'(third_reg.gain);
      OFS_THIRD_BIAS:  rdata_next = 32'(third_reg.bias);
      OFS_FILTER:      rdata_next = {24'h00_0000, filter_reg};
      OFS_STATUS: begin
        rdata_next[STS_RUN_BIT]    = DRIVE_RUN;
        rdata_next[STS_REJECT_BIT] = reject_reg;
        rdata_next[STS_JUMPER_BIT] =
          (cfg_reg.second_input_level_select == LVL_CURRENT)
          != CURRENT_VOLTAGE_JUMPER;
      end
      OFS_MAIN_REF:    rdata_next = 32'(MAIN_REF);
      OFS_SECOND_OUT:  rdata_next = 32'(SECOND_OUT);
      OFS_THIRD_OUT:   rdata_next = 32'(THIRD_OUT);
      default:         rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (WB_CYC && WB_STB && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  always_comb begin
    wval = 32'h0000_0000;
    unique case (WB_ADR)
      OFS_CFG:         wval = merge({18'h0_0000, cfg_reg}, WB_DAT_I, WB_SEL);
      OFS_MAIN_GAIN:   wval = merge(32'(main_reg.gain), WB_DAT_I, WB_SEL);
      OFS_MAIN_BIAS:   wval = merge(32'(main_reg.bias), WB_DAT_I, WB_SEL);
      OFS_SECOND_GAIN: wval = merge(32'(second_reg.gain), WB_DAT_I, WB_SEL);
      OFS_SECOND_BIAS: wval = merge(32'(second_reg.bias), WB_DAT_I, WB_SEL);
      OFS_THIRD_GAIN:  wval = merge(32'(third_reg.gain), WB_DAT_I, WB_SEL);
      OFS_THIRD_BIAS:  wval = merge(32'(third_reg.bias), WB_DAT_I, WB_SEL);
      OFS_FILTER:      wval = merge({24'h00_0000, filter_reg}, WB_DAT_I,
                                    WB_SEL);
      default:         wval = 32'h0000_0000;
    endcase
    cfg_new = ars_cfg_t'(wval[CFG_W-1:0]);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cfg_reg    <= CFG_RST;
      filter_reg <= FILTER_RST;
      reject_reg <= 1'b0;
    end else if (wr_fire && WB_ADR == OFS_CFG) begin
      if (DRIVE_RUN || cfg_new.second_input_level_select > LVL_CURRENT
          || cfg_new.third_input_function_select == 5'h00) begin
        reject_reg <= 1'b1;
      end else begin
        cfg_reg    <= cfg_new;
        reject_reg <= 1'b0;
      end
    end else if (wr_fire && WB_ADR == OFS_FILTER) begin
      if (DRIVE_RUN || wval[7:0] > FILTER_MAX) begin
        reject_reg <= 1'b1;
      end else begin
        filter_reg <= wval[7:0];
        reject_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      main_reg   <= '{GAIN_RST, BIAS_RST};
      second_reg <= '{GAIN_RST, BIAS_RST};
      third_reg  <= '{GAIN_RST, BIAS_RST};
    end else if (wr_fire) begin
      unique case (WB_ADR)
        OFS_MAIN_GAIN:   if (gain_ok(wval)) main_reg.gain <= wval[15:0];
        OFS_MAIN_BIAS:   if (bias_ok(wval)) main_reg.bias <= wval[15:0];
        OFS_SECOND_GAIN: if (gain_ok(wval))
                           second_reg.gain <= wval[15:0];
        OFS_SECOND_BIAS: if (bias_ok(wval))
                           second_reg.bias <= wval[15:0];
        OFS_THIRD_GAIN:  if (gain_ok(wval))
                           third_reg.gain <= wval[15:0];
        OFS_THIRD_BIAS:  if (bias_ok(wval))
                           third_reg.bias <= wval[15:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sample tick and shared filter
  // ---------------------------------------------------------------
  logic [31:0]        tick_cnt_reg;
  logic               tick_reg;
  logic signed [11:0] x [3];
  logic signed [19:0] acc_reg [3];
  logic [4:0]         sh;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1))
                      ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  assign sh = shift_of(filter_reg);
  assign x[0] = norm(MAIN_REFERENCE_INPUT_MAG, MAIN_REFERENCE_INPUT_NEG,
                     {1'b0, cfg_reg.main_input_level_select});
  assign x[1] = norm(SECOND_REFERENCE_INPUT_MAG, SECOND_REFERENCE_INPUT_NEG,
                     cfg_reg.second_input_level_select);
  assign x[2] = norm(THIRD_REFERENCE_INPUT_MAG, THIRD_REFERENCE_INPUT_NEG,
                     {1'b0, cfg_reg.third_input_level_select});

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      for (int i = 0; i < 3; i++) begin
        acc_reg[i] <= 20'sh0_0000;
      end
    end else if (tick_reg) begin
      for (int i = 0; i < 3; i++) begin
        acc_reg[i] <= acc_reg[i]
          + 20'(($signed({x[i], 8'h00}) - acc_reg[i]) >>> sh);
      end
    end
  end

  // ---------------------------------------------------------------
  // scaling and combination
  // ---------------------------------------------------------------
  logic               upd_reg;
  logic signed [31:0] sec_v;
  logic signed [31:0] thr_v;
  logic signed [31:0] gain_eff;
  logic signed [31:0] bias_sum;
  logic signed [31:0] main_v;

  always_comb begin
    sec_v = scale(acc_reg[1][19:8], 32'(second_reg.gain),
                  32'(second_reg.bias));
    thr_v = scale(acc_reg[2][19:8], 32'(third_reg.gain),
                  32'(third_reg.bias));
    gain_eff = 32'(main_reg.gain);
    bias_sum = 32'sh0000_0000;
    if (cfg_reg.second_input_function_select == FN_GAIN_ADD) begin
      gain_eff = gain_eff + sec_v;
    end
    if (cfg_reg.third_input_function_select == FN_GAIN_ADD) begin
      gain_eff = gain_eff + thr_v;
    end
    if (cfg_reg.second_input_function_select == FN_BIAS_ADD) begin
      bias_sum = bias_sum + sec_v;
    end
    if (cfg_reg.third_input_function_select == FN_BIAS_ADD) begin
      bias_sum = bias_sum + thr_v;
    end
    main_v = scale(acc_reg[0][19:8], gain_eff, 32'(main_reg.bias))
             + bias_sum;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      upd_reg    <= 1'b0;
      REF_STROBE <= 1'b0;
      MAIN_REF   <= '0;
      SECOND_OUT <= '0;
      THIRD_OUT  <= '0;
    end else begin
      upd_reg    <= tick_reg;
      REF_STROBE <= upd_reg;
      if (upd_reg) begin
        MAIN_REF   <= main_v[OUT_W-1:0];
        SECOND_OUT <= sec_v[OUT_W-1:0];
        THIRD_OUT  <= thr_v[OUT_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// ---- testbench/ars_src_model.sv ----
`default_nettype none
// ---------------------------------------------------------------
// analog sources behind the converters
// ---------------------------------------------------------------
module ars_src_model (
  input  wire logic        clk,
  input  wire logic [35:0] level,
  output logic      [35:0] sample
);
  timeunit 1ns;
  timeprecision 1ps;
  // converter result lags the source by one cycle
  always_ff @(posedge clk) begin
    sample <= level;
  end
endmodule
`default_nettype wire

// ---- testbench/ars_scaler_properties.sv ----
`default_nettype none
module ars_scaler_properties
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic                   CLK_SYS,
  input wire logic                   NRST,
  input wire logic                   WB_STB,
  input wire logic                   WB_CYC,
  input wire logic                   WB_ACK,
  input wire logic [31:0]            WB_DAT_O,
  input wire logic signed [OUT_W-1:0] MAIN_REF,
  input wire logic signed [OUT_W-1:0] SECOND_OUT,
  input wire logic signed [OUT_W-1:0] THIRD_OUT,
  input wire logic                   REF_STROBE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_reg;
  logic        seen_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // ---------------------------------------------------------------
  // cycles since the last output strobe
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end else if (REF_STROBE) begin
      gap_reg  <= '0;
      seen_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 32'h0000_0001;
    end
  end
  a_ack_one_shot: assert property (
    WB_ACK |=> !WB_ACK) else $error("ack held too long");
  a_ack_answers_req: assert property (
    (WB_CYC && WB_STB && !WB_ACK) |=> WB_ACK) else $error("no ack");
  a_ack_idle_quiet: assert property (
    !(WB_CYC && WB_STB) |=> !WB_ACK) else $error("ack without request");
  a_rdata_hold: assert property (
    $changed(WB_DAT_O) |-> WB_ACK) else $error("read data moved");
  a_strobe_pulse: assert property (
    REF_STROBE |=> !REF_STROBE) else $error("strobe too long");
  a_out_with_strobe: assert property (
    ($changed(MAIN_REF) || $changed(SECOND_OUT) || $changed(THIRD_OUT))
      |-> REF_STROBE) else $error("output moved without strobe");
  a_strobe_period: assert property (
    (REF_STROBE && seen_reg) |-> gap_reg == 32'(TICK_CYCLES - 1))
    else $error("strobe period wrong");
  a_strobe_bound: assert property (
    seen_reg |-> gap_reg <= 32'(TICK_CYCLES - 1))
    else $error("strobe missing");
endmodule
bind ars_scaler ars_scaler_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) ars_scaler_properties_inst (
  .CLK_SYS(CLK_SYS),
  .NRST(NRST),
  .WB_STB(WB_STB),
  .WB_CYC(WB_CYC),
  .WB_ACK(WB_ACK),
  .WB_DAT_O(WB_DAT_O),
  .MAIN_REF(MAIN_REF),
  .SECOND_OUT(SECOND_OUT),
  .THIRD_OUT(THIRD_OUT),
  .REF_STROBE(REF_STROBE)
);
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb
  import ars_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys   = 1'b0;
  logic                    nrst      = 1'b0;
  logic [7:0]              wb_adr    = '0;
  logic [31:0]             wb_dat_i  = '0;
  logic [3:0]              wb_sel    = '0;
  logic [3:0]              sel_use   = 4'hf;
  logic                    wb_we     = 1'b0;
  logic                    wb_stb    = 1'b0;
  logic                    wb_cyc    = 1'b0;
  logic                    drive_run = 1'b0;
  logic                    jumper    = 1'b1;
  logic [35:0]             level     = '0;
  logic [35:0]             sample;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack;
  logic                    ref_strobe;
  logic signed [OUT_W-1:0] main_ref;
  logic signed [OUT_W-1:0] second_out;
  logic signed [OUT_W-1:0] third_out;
  logic [31:0]             rd;
  int                      err_count = 0;
  int                      checks    = 0;
  int                      g [3]     = '{1000, 1000, 1000};
  int                      b [3]     = '{0, 0, 0};
  always #2 clk_sys = ~clk_sys;
  ars_src_model ars_src_model_inst (.clk(clk_sys), .level(level),
    .sample(sample));
  ars_scaler #(.TICK_CYCLES(20)) ars_scaler_inst (
    .CLK_SYS(clk_sys), .NRST(nrst), .WB_ADR(wb_adr), .WB_DAT_I(wb_dat_i),
    .WB_SEL(wb_sel), .WB_WE(wb_we), .WB_STB(wb_stb), .WB_CYC(wb_cyc),
    .WB_DAT_O(wb_dat_o), .WB_ACK(wb_ack), .DRIVE_RUN(drive_run),
    .CURRENT_VOLTAGE_JUMPER(jumper),
    .MAIN_REFERENCE_INPUT_MAG(sample[10:0]),
    .MAIN_REFERENCE_INPUT_NEG(sample[11]),
    .SECOND_REFERENCE_INPUT_MAG(sample[22:12]),
    .SECOND_REFERENCE_INPUT_NEG(sample[23]),
    .THIRD_REFERENCE_INPUT_MAG(sample[34:24]),
    .THIRD_REFERENCE_INPUT_NEG(sample[35]),
    .MAIN_REF(main_ref), .SECOND_OUT(second_out), .THIRD_OUT(third_out),
    .REF_STROBE(ref_strobe));
  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic int norm(input int mag, input int neg, input int lvl);
    if (lvl == 2) begin
      if (mag <= 410) return 0;
      return ((mag - 410) * 5 / 4 > 2047) ? 2047 : (mag - 410) * 5 / 4;
    end
    if (neg != 0) return (lvl == 1) ? -mag : 0;
    return mag;
  endfunction
  function automatic int lin(input int s, input int gn, input int bs);
    return bs + (((gn - bs) * s) >>> 11);
  endfunction
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // classic single bus cycle
  // ---------------------------------------------------------------
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_adr   <= a;
    wb_we    <= we;
    wb_dat_i <= d;
    wb_sel   <= sel_use;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) err_count++;
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic run_case(input logic [31:0] cfg, input logic [35:0] lv);
    ars_cfg_t c;
    int s0, s1, s2, o1, o2, eg, em, n;
    c = ars_cfg_t'(cfg[CFG_W-1:0]);
    wb(OFS_CFG, 1'b1, cfg);
    level <= lv;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (ref_strobe !== 1'b1 && n < 100);
      if (ref_strobe !== 1'b1) err_count++;
    end
    s0 = norm(lv[10:0], lv[11], c.main_input_level_select);
    s1 = norm(lv[22:12], lv[23], c.second_input_level_select);
    s2 = norm(lv[34:24], lv[35], c.third_input_level_select);
    o1 = lin(s1, g[1], b[1]);
    o2 = lin(s2, g[2], b[2]);
    eg = g[0] + (c.second_input_function_select == FN_GAIN_ADD ? o1 : 0)
      + (c.third_input_function_select == FN_GAIN_ADD ? o2 : 0);
    em = lin(s0, eg, b[0])
      + (c.second_input_function_select == FN_BIAS_ADD ? o1 : 0);
    chk(32'(main_ref), 32'(em));
    chk(32'(second_out), 32'(o1));
    chk(32'(third_out), 32'(o2));
    rdc(OFS_STATUS,
        32'(c.second_input_level_select != LVL_CURRENT) << 2);
    rdc(OFS_MAIN_REF, 32'(em));
    rdc(OFS_SECOND_OUT, 32'(o1));
    rdc(OFS_THIRD_OUT, 32'(o2));
  endtask
  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  ra [10];
    logic [31:0] rv [10];
    logic [35:0] lv [4];
    logic [31:0] cf [4];
    logic [7:0]  ga;
    ra = '{OFS_CFG, OFS_MAIN_GAIN, OFS_MAIN_BIAS, OFS_SECOND_GAIN,
      OFS_SECOND_BIAS, OFS_THIRD_GAIN, OFS_THIRD_BIAS, OFS_FILTER,
      OFS_STATUS, 8'h30};
    rv = '{32'h0000_0408, 32'h0000_03e8, 32'h0000_0000, 32'h0000_03e8,
      32'h0000_0000, 32'h0000_03e8, 32'h0000_0000, 32'h0000_0003,
      32'h0000_0000, 32'h0000_0000};
    cf = '{32'h0000_0408, 32'h0000_0409, 32'h0000_0413, 32'h0000_0204};
    lv = '{{1'b0, 11'h7ff, 1'b0, 11'h3e8, 1'b1, 11'h400},
      {1'b1, 11'h200, 1'b0, 11'h12c, 1'b1, 11'h400},
      {1'b1, 11'h200, 1'b0, 11'h400, 1'b0, 11'h7ff},
      {1'b0, 11'h7ff, 1'b1, 11'h100, 1'b0, 11'h200}};
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (ra[i]) begin
      rdc(ra[i], rv[i]);
    end
    for (int i = 0; i < 3; i++) begin
      ga = OFS_MAIN_GAIN + 8'(8 * i);
      wb(ga, 1'b1, 32'h0000_2711);
      rdc(ga, 32'h0000_03e8);
      wb(ga, 1'b1, 32'h0000_2710);
      rdc(ga, 32'h0000_2710);
      wb(ga + 8'h04, 1'b1, 32'hffff_fc17);
      rdc(ga + 8'h04, 32'h0000_0000);
      wb(ga + 8'h04, 1'b1, 32'hffff_fc18);
      rdc(ga + 8'h04, 32'hffff_fc18);
      wb(ga, 1'b1, 32'h0000_03e8);
      wb(ga + 8'h04, 1'b1, 32'h0000_0000);
    end
    sel_use = 4'h1;
    wb(OFS_MAIN_GAIN, 1'b1, 32'hffff_ff10);
    sel_use = 4'hf;
    rdc(OFS_MAIN_GAIN, 32'h0000_0310);
    wb(OFS_CFG, 1'b1, 32'h0000_0008);
    rdc(OFS_CFG, 32'h0000_0408);
    rdc(OFS_STATUS, 32'h0000_0002);
    wb(OFS_CFG, 1'b1, 32'h0000_040c);
    rdc(OFS_CFG, 32'h0000_0408);
    wb(OFS_FILTER, 1'b1, 32'h0000_00c9);
    rdc(OFS_FILTER, 32'h0000_0003);
    wb(OFS_FILTER, 1'b1, 32'h0000_00c8);
    rdc(OFS_FILTER, 32'h0000_00c8);
    rdc(OFS_STATUS, 32'h0000_0000);
    drive_run <= 1'b1;
    wb(OFS_CFG, 1'b1, 32'h0000_0409);
    wb(OFS_FILTER, 1'b1, 32'h0000_0000);
    wb(OFS_MAIN_GAIN, 1'b1, 32'h0000_01f4);
    rdc(OFS_CFG, 32'h0000_0408);
    rdc(OFS_FILTER, 32'h0000_00c8);
    rdc(OFS_MAIN_GAIN, 32'h0000_01f4);
    rdc(OFS_STATUS, 32'h0000_0003);
    drive_run <= 1'b0;
    wb(OFS_MAIN_BIAS, 1'b1, 32'h0000_0064);
    wb(OFS_SECOND_GAIN, 1'b1, 32'h0000_07d0);
    wb(OFS_THIRD_BIAS, 1'b1, 32'hffff_ffce);
    wb(OFS_FILTER, 1'b1, 32'h0000_0000);
    g = '{500, 2000, 1000};
    b = '{100, 0, -50};
    foreach (cf[i]) begin
      run_case(cf[i], lv[i]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
